// ===== common/vtg_pkg.sv
package vtg_pkg;

   // Breakpoint table: entry n at BP_BASE + 2n, even byte {kind, 0, line[10:8]}, odd byte line[7:0]
   localparam logic [7:0] BP_BASE = 8'h50;
   localparam logic [7:0] BP_LAST = 8'h6F;
   localparam logic [7:0] BP_HI_MASK = 8'hF7;
   localparam int BP_DEPTH = 16;

   localparam logic [7:0] REG_FIRST = 8'h70;
   localparam logic [7:0] HSW_LO = 8'h70;
   localparam logic [7:0] HSW_HST_HI = 8'h71;
   localparam logic [7:0] HST_LO = 8'h72;
   localparam logic [7:0] VW1_LO = 8'h73;
   localparam logic [7:0] V1_HI = 8'h74;
   localparam logic [7:0] VS1_LO = 8'h75;
   localparam logic [7:0] VW2_LO = 8'h76;
   localparam logic [7:0] V2_HI = 8'h77;
   localparam logic [7:0] VS2_LO = 8'h78;
   localparam logic [7:0] SUH_HI = 8'h79;
   localparam logic [7:0] SUH_LO = 8'h7A;
   localparam logic [7:0] SUV_HI = 8'h7B;
   localparam logic [7:0] SUV_LO = 8'h7C;
   localparam logic [7:0] PPL_HI = 8'h7D;
   localparam logic [7:0] PPL_LO = 8'h7E;
   localparam logic [7:0] SCAN_HI = 8'h7F;
   localparam logic [7:0] LPF_LO = 8'h80;
   localparam logic [7:0] FMT_SEL = 8'h81;
   localparam logic [7:0] CTRL = 8'h82;
   localparam logic [7:0] REG_LAST = 8'h82;
   localparam int REG_COUNT = 19;

   // Field positions
   localparam int WIDTH_HI_POS = 6;
   localparam int INTERLACE_POS = 7;
   localparam int CTL_FIELD_ROLE = 7;
   localparam int CTL_COLOUR = 6;
   localparam int CTL_SYNC_SRC = 5;
   localparam int CTL_VS_POL = 4;
   localparam int CTL_HS_POL = 3;
   localparam int CTL_FID_POL = 2;
   localparam int CTL_VSIN_POL = 1;
   localparam int CTL_HSIN_POL = 0;

   // Reset values per byte
   localparam logic [7:0] RST_HSW_LO = 8'h60;
   localparam logic [7:0] RST_HST_LO = 8'h02;
   localparam logic [7:0] RST_VW1_LO = 8'h03;
   localparam logic [7:0] RST_VS1_LO = 8'h03;
   localparam logic [7:0] RST_V2_HI = 8'h07;
   localparam logic [7:0] RST_VS2_LO = 8'hFF;
   localparam logic [7:0] RST_SUH_LO = 8'h3D;
   localparam logic [7:0] RST_SUV_LO = 8'h03;
   localparam logic [7:0] RST_FMT_SEL = 8'h06;
   localparam logic [7:0] RST_CTRL = 8'h5F;
   localparam logic [7:0] RST_ZERO = 8'h00;

   localparam logic [REG_COUNT-1:0][7:0] REG_RESET = {
      RST_CTRL, RST_FMT_SEL, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_SUV_LO, RST_ZERO,
      RST_SUH_LO, RST_ZERO, RST_VS2_LO, RST_V2_HI, RST_ZERO, RST_VS1_LO, RST_ZERO, RST_VW1_LO,
      RST_HST_LO, RST_ZERO, RST_HSW_LO};
   // Writable bits; read-only counters have none
   localparam logic [REG_COUNT-1:0][7:0] REG_WMASK = {
      8'hFF, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h07,
      8'hFF, 8'h1F, 8'hFF, 8'hC7, 8'hFF, 8'hFF, 8'hC7, 8'hFF,
      8'hFF, 8'hDF, 8'hFF};

   localparam logic [3:0] MODE_VESA_MASTER = 4'h6;
   localparam logic [3:0] MODE_VESA_SLAVE = 4'h7;
   localparam logic [3:0] KIND_ACTIVE = 4'h0;

   localparam logic [9:0] CODE_ONES = 10'h3FF;
   localparam logic [9:0] CODE_ZERO = 10'h000;
   localparam int XYZ_F = 8;
   localparam int XYZ_V = 7;
   localparam int XYZ_H = 6;

   localparam logic [9:0] BLANK_LOW = 10'h000;
   localparam logic [9:0] BLANK_MID = 10'h200;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LINES = 3'b010,
      ST_PIXELS = 3'b100
   } phase_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [9:0] y;
      logic [9:0] cb;
      logic [9:0] cr;
   } vid_px_t;

   typedef struct packed {
      logic hsync;
      logic vsync;
      logic field;
      logic [9:0] y;
      logic [9:0] cb;
      logic [9:0] cr;
   } vid_in_t;

endpackage

// ===== core/bp_table.sv
`timescale 1ns/1ps
module bp_table
#(
   parameter int DEPTH = 16
)
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH):0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [$clog2(DEPTH):0] rd_addr,
   output logic [7:0] rd_byte,
   input wire logic [$clog2(DEPTH)-1:0] look_addr,
   output logic [15:0] look_data
);
   import vtg_pkg::*;

   typedef struct packed {
      logic [DEPTH-1:0][1:0][7:0] mem;
      logic [7:0] rd_byte;
      logic [15:0] look;
   } state_t;

   state_t st;
   state_t next_st;

   // Even byte address holds the upper half of an entry
   always_comb
   begin
      next_st = st;
      if (wr_en)
      begin
         next_st.mem[wr_addr[$clog2(DEPTH):1]][~wr_addr[0]] = wr_data;
      end
      next_st.rd_byte = st.mem[rd_addr[$clog2(DEPTH):1]][~rd_addr[0]];
      next_st.look = st.mem[look_addr];
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign rd_byte = st.rd_byte;
   assign look_data = st.look;

endmodule // bp_table

// ===== core/sync_window.sv
`timescale 1ns/1ps
module sync_window
#(
   parameter int CW = 16,
   parameter int NWIN = 1
)
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic enable,
   input wire logic active_high,
   input wire logic [CW-1:0] count,
   input wire logic [CW-1:0] total,
   input wire logic [NWIN-1:0][CW-1:0] start,
   input wire logic [NWIN-1:0][CW-1:0] width,
   output logic level
);
   import vtg_pkg::*;

   typedef struct packed {
      logic level;
   } state_t;

   state_t st;
   state_t next_st;
   logic [NWIN-1:0] hit;

   // A start beyond the total is never reached, so that window stays silent
   for (genvar w = 0; w < NWIN; w++)
   begin : g_win
      assign hit[w] = (start[w] <= total) && (count >= start[w]) &&
         ({1'b0, count} < ({1'b0, start[w]} + {1'b0, width[w]}));
   end

   always_comb
   begin
      next_st = st;
      next_st.level = (enable & (|hit)) ~^ active_high;
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign level = st.level;

endmodule // sync_window

// ===== core/video_timing_output.sv
`timescale 1ns/1ps
module video_timing_output
#(
   parameter logic [15:0] ALIGN_TOL = 16'h0010
)
(
   input wire logic mclk,
   input wire logic arst_n,
   input vtg_pkg::reg_req_t bus,
   output logic [7:0] rdata,
   input vtg_pkg::vid_in_t vin,
   output vtg_pkg::vid_px_t vout,
   output logic hsync_output,
   output logic vsync_output,
   output logic [3:0] line_kind
);
   import vtg_pkg::*;

   typedef struct packed {
      logic [REG_COUNT-1:0][7:0] regs;
      logic [7:0] rdata;
      logic bp_rd;
      logic hs_prev;
      logic vs_prev;
      logic v_prev;
      logic [9:0] y_d1;
      logic [9:0] y_d2;
      logic [9:0] y_d3;
      logic [15:0] in_pix;
      logic [15:0] pix_meas;
      logic [10:0] line_ctr;
      logic [10:0] line_meas;
      logic seen_f2;
      logic interlace;
      phase_t phase;
      logic [10:0] vcount;
      logic [12:0] hcount;
      logic running;
      logic [15:0] out_pix;
      logic [10:0] out_line;
      logic [3:0] pos;
      logic bp_done;
      logic [3:0] kind;
      vid_px_t px;
   } state_t;

   state_t st;
   state_t next_st;

   function automatic logic [4:0] ix(input logic [7:0] off);
      ix = 5'(off - REG_FIRST);
   endfunction

   logic in_regs;
   logic in_bp;
   logic [4:0] bp_addr;
   logic [7:0] bp_byte;
   logic [15:0] look_data;
   logic [REG_COUNT-1:0][7:0] view;

   logic [9:0] hsync_out_width;
   logic [12:0] hsync_out_start;
   logic [9:0] vsync_out_width_field1;
   logic [10:0] vsync_out_start_field1;
   logic [9:0] vsync_out_width_field2;
   logic [10:0] vsync_out_start_field2;
   logic [12:0] startup_horizontal_delay;
   logic [10:0] startup_vertical_delay;
   logic [3:0] timing_format_select;
   logic field_pin_role_select;
   logic colour_format_select;
   logic sync_source_select;
   logic vsync_out_polarity;
   logic hsync_out_polarity;
   logic field_id_polarity;
   logic hsync_in_polarity;
   logic vsync_in_polarity;

   logic vesa;
   logic de_mode;
   logic hs_lvl;
   logic vs_lvl;
   logic code_hit;
   logic eav;
   logic line_evt;
   logic vert_evt;
   logic field_now;
   logic field_derived;
   logic frame_start;
   logic last_pix;

   assign in_regs = (bus.addr >= REG_FIRST) && (bus.addr <= REG_LAST);
   assign in_bp = (bus.addr >= BP_BASE) && (bus.addr <= BP_LAST);
   assign bp_addr = 5'(bus.addr - BP_BASE);

   // Multi-byte fields
   assign hsync_out_width = {st.regs[ix(HSW_HST_HI)][7:WIDTH_HI_POS], st.regs[ix(HSW_LO)]};
   assign hsync_out_start = {st.regs[ix(HSW_HST_HI)][4:0], st.regs[ix(HST_LO)]};
   assign vsync_out_width_field1 = {st.regs[ix(V1_HI)][7:WIDTH_HI_POS], st.regs[ix(VW1_LO)]};
   assign vsync_out_start_field1 = {st.regs[ix(V1_HI)][2:0], st.regs[ix(VS1_LO)]};
   assign vsync_out_width_field2 = {st.regs[ix(V2_HI)][7:WIDTH_HI_POS], st.regs[ix(VW2_LO)]};
   assign vsync_out_start_field2 = {st.regs[ix(V2_HI)][2:0], st.regs[ix(VS2_LO)]};
   assign startup_horizontal_delay = {st.regs[ix(SUH_HI)][4:0], st.regs[ix(SUH_LO)]};
   assign startup_vertical_delay = {st.regs[ix(SUV_HI)][2:0], st.regs[ix(SUV_LO)]};
   assign timing_format_select = st.regs[ix(FMT_SEL)][3:0];
   assign field_pin_role_select = st.regs[ix(CTRL)][CTL_FIELD_ROLE];
   assign colour_format_select = st.regs[ix(CTRL)][CTL_COLOUR];
   assign sync_source_select = st.regs[ix(CTRL)][CTL_SYNC_SRC];
   assign vsync_out_polarity = st.regs[ix(CTRL)][CTL_VS_POL];
   assign hsync_out_polarity = st.regs[ix(CTRL)][CTL_HS_POL];
   assign field_id_polarity = st.regs[ix(CTRL)][CTL_FID_POL];
   assign vsync_in_polarity = st.regs[ix(CTRL)][CTL_VSIN_POL];
   assign hsync_in_polarity = st.regs[ix(CTRL)][CTL_HSIN_POL];

   assign vesa = (timing_format_select == MODE_VESA_MASTER) ||
      (timing_format_select == MODE_VESA_SLAVE);
   assign de_mode = field_pin_role_select && vesa;

   // Input polarity bits: 1 means the pin is active high
   assign hs_lvl = vin.hsync ~^ hsync_in_polarity;
   assign vs_lvl = vin.vsync ~^ vsync_in_polarity;

   // Embedded codes ride on the luma word: ones, zero, zero, then the flag word
   assign code_hit = (st.y_d3 == CODE_ONES) && (st.y_d2 == CODE_ZERO) && (st.y_d1 == CODE_ZERO);
   assign eav = sync_source_select && code_hit && vin.y[XYZ_H];

   always_comb
   begin
      if (sync_source_select)
      begin
         line_evt = eav;
         vert_evt = eav && vin.y[XYZ_V] && !st.v_prev;
      end
      else
      begin
         line_evt = hs_lvl && !st.hs_prev;
         vert_evt = vs_lvl && !st.vs_prev;
      end
   end

   // Vertical edge well inside a line marks the second field
   assign field_derived = (st.in_pix > ALIGN_TOL) &&
      (({1'b0, st.in_pix} + {1'b0, ALIGN_TOL}) < {1'b0, st.pix_meas});

   always_comb
   begin
      if (sync_source_select)
      begin
         field_now = vin.y[XYZ_F];
      end
      else if (!field_pin_role_select)
      begin
         field_now = vin.field ~^ field_id_polarity;
      end
      else if (vesa)
      begin
         field_now = 1'b0;
      end
      else
      begin
         field_now = field_derived;
      end
   end

   assign frame_start = vert_evt && !field_now;
   assign last_pix = (st.out_pix == 16'(st.pix_meas - 16'h0001));

   // Register view with live readbacks folded in
   always_comb
   begin
      view = st.regs;
      view[ix(PPL_HI)] = st.pix_meas[15:8];
      view[ix(PPL_LO)] = st.pix_meas[7:0];
      view[ix(SCAN_HI)] = {st.interlace, 4'h0, st.line_meas[10:8]};
      view[ix(LPF_LO)] = st.line_meas[7:0];
   end

   always_comb
   begin
      next_st = st;

      // Register port
      next_st.rdata = 8'h00;
      next_st.bp_rd = 1'b0;
      if (bus.rd && in_regs)
      begin
         next_st.rdata = view[ix(bus.addr)];
      end
      if (bus.rd && in_bp)
      begin
         next_st.bp_rd = 1'b1;
      end
      if (bus.wr && in_regs)
      begin
         next_st.regs[ix(bus.addr)] = (st.regs[ix(bus.addr)] & ~REG_WMASK[ix(bus.addr)]) |
            (bus.wdata & REG_WMASK[ix(bus.addr)]);
      end

      // Input history
      next_st.hs_prev = hs_lvl;
      next_st.vs_prev = vs_lvl;
      next_st.y_d1 = vin.y;
      next_st.y_d2 = st.y_d1;
      next_st.y_d3 = st.y_d2;
      if (eav)
      begin
         next_st.v_prev = vin.y[XYZ_V];
      end

      // Measurements land when an edge closes an interval; the first after reset counts from release
      if (line_evt)
      begin
         next_st.pix_meas = 16'(st.in_pix + 16'h0001);
         next_st.in_pix = 16'h0000;
      end
      else if (st.in_pix != 16'hFFFF)
      begin
         next_st.in_pix = 16'(st.in_pix + 16'h0001);
      end

      if (frame_start)
      begin
         next_st.line_meas = 11'(st.line_ctr + {10'h000, line_evt});
         next_st.line_ctr = 11'h000;
         next_st.interlace = st.seen_f2;
         next_st.seen_f2 = 1'b0;
      end
      else
      begin
         next_st.line_ctr = 11'(st.line_ctr + {10'h000, line_evt});
         if (vert_evt && field_now)
         begin
            next_st.seen_f2 = 1'b1;
         end
      end

      // Free-running output raster
      if (st.running)
      begin
         if (last_pix)
         begin
            next_st.out_pix = 16'h0000;
            if (st.out_line == st.line_meas)
            begin
               next_st.out_line = 11'h001;
               next_st.pos = 4'h0;
               next_st.bp_done = 1'b0;
            end
            else
            begin
               next_st.out_line = 11'(st.out_line + 11'h001);
            end
         end
         else
         begin
            next_st.out_pix = 16'(st.out_pix + 16'h0001);
         end
      end

      // Breakpoint walk; the table is addressed with the next pointer, so its data match pos
      if (st.running && !st.bp_done && (st.out_line == look_data[10:0]))
      begin
         next_st.kind = look_data[15:12];
         if (st.pos == 4'(BP_DEPTH - 1))
         begin
            next_st.bp_done = 1'b1;
         end
         else
         begin
            next_st.pos = 4'(st.pos + 4'h1);
         end
      end

      // Startup delay, rearmed on every frame reference
      if (frame_start)
      begin
         if (startup_vertical_delay == 11'h000)
         begin
            next_st.phase = ST_PIXELS;
            next_st.hcount = startup_horizontal_delay;
         end
         else
         begin
            next_st.phase = ST_LINES;
            next_st.vcount = startup_vertical_delay;
         end
      end
      else
      begin
         unique case (st.phase)
            ST_IDLE:
            begin
               next_st.phase = ST_IDLE;
            end
            ST_LINES:
            begin
               if (line_evt)
               begin
                  if (st.vcount <= 11'h001)
                  begin
                     next_st.phase = ST_PIXELS;
                     next_st.hcount = startup_horizontal_delay;
                  end
                  else
                  begin
                     next_st.vcount = 11'(st.vcount - 11'h001);
                  end
               end
            end
            ST_PIXELS:
            begin
               if (st.hcount == 13'h0000)
               begin
                  next_st.phase = ST_IDLE;
                  next_st.running = 1'b1;
                  next_st.out_pix = 16'h0000;
                  next_st.out_line = 11'h001;
                  next_st.pos = 4'h0;
                  next_st.bp_done = 1'b0;
               end
               else
               begin
                  next_st.hcount = 13'(st.hcount - 13'h0001);
               end
            end
            default:
            begin
               next_st.phase = ST_IDLE;
            end
         endcase
      end

      // Data gate; luma blanks to BLANK_LOW, chroma blanking levels follow the colour format
      if (de_mode && !vin.field)
      begin
         next_st.px.y = BLANK_LOW;
         next_st.px.cb = colour_format_select ? BLANK_LOW : BLANK_MID;
         next_st.px.cr = colour_format_select ? BLANK_LOW : BLANK_MID;
      end
      else
      begin
         next_st.px.y = vin.y;
         next_st.px.cb = vin.cb;
         next_st.px.cr = vin.cr;
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st <= '0;
         st.regs <= REG_RESET;
         st.phase <= ST_IDLE;
         // A sync already active at release is no edge, so the first measurement runs from release to the next edge
         st.hs_prev <= 1'b1;
         st.vs_prev <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   bp_table #(
      .DEPTH(BP_DEPTH)
   ) u_bp_table (
      .mclk(mclk),
      .arst_n(arst_n),
      .wr_en(bus.wr && in_bp),
      .wr_addr(bp_addr),
      .wr_data(bp_addr[0] ? bus.wdata : (bus.wdata & BP_HI_MASK)),
      .rd_addr(bp_addr),
      .rd_byte(bp_byte),
      .look_addr(next_st.pos),
      .look_data(look_data)
   );

   sync_window #(
      .CW(16),
      .NWIN(1)
   ) u_hsync (
      .mclk(mclk),
      .arst_n(arst_n),
      .enable(st.running),
      .active_high(hsync_out_polarity),
      .count(st.out_pix),
      .total(st.pix_meas),
      .start({3'b000, hsync_out_start}),
      .width({6'h00, hsync_out_width}),
      .level(hsync_output)
   );

   // Field-2 window relies on the host parking it out of range for progressive formats
   sync_window #(
      .CW(11),
      .NWIN(2)
   ) u_vsync (
      .mclk(mclk),
      .arst_n(arst_n),
      .enable(st.running),
      .active_high(~vsync_out_polarity),
      .count(st.out_line),
      .total(st.line_meas),
      .start({vsync_out_start_field2, vsync_out_start_field1}),
      .width({1'b0, vsync_out_width_field2, 1'b0, vsync_out_width_field1}),
      .level(vsync_output)
   );

   assign rdata = st.bp_rd ? bp_byte : st.rdata;
   assign vout = st.px;
   assign line_kind = st.kind;

endmodule // video_timing_output

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import vtg_pkg::*;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic ilace = 1'b0;
   reg_req_t bus = '0;
   vid_in_t vin;
   vid_px_t vout;
   logic [7:0] rdata;
   logic hsync_output;
   logic vsync_output;
   logic [3:0] line_kind;
   int num_errors = 0;
   int cmp_count = 0;
   int n3;
   int na;
   logic [7:0] ra [11] = '{HSW_LO, HST_LO, VW1_LO, VS1_LO, V2_HI, VS2_LO, SUH_LO, SUV_LO,
      FMT_SEL, CTRL, PPL_HI};
   logic [7:0] rv [11] = '{8'h60, 8'h02, 8'h03, 8'h03, 8'h07, 8'hFF, 8'h3D, 8'h03,
      8'h06, 8'h5F, 8'h00};

   always #4 mclk = ~mclk;

   vid_src src (.mclk(mclk), .arst_n(arst_n), .ilace(ilace), .vin(vin));
   video_timing_output DUT (.mclk(mclk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
      .vin(vin), .vout(vout), .hsync_output(hsync_output), .vsync_output(vsync_output),
      .line_kind(line_kind));

   task automatic complete_run();
      $display("mismatches %0d, comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge mclk);
      bus.rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask

   task automatic wait_for(input bit vs, input logic lvl);
      int n;
      n = 0;
      while ((vs ? vsync_output : hsync_output) !== lvl)
      begin
         @(posedge mclk);
         #1;
         n++;
         if (n > 4000)
         begin
            num_errors++;
            $display("unexpected hang at %0t: sync level never reached", $time);
            complete_run();
         end
      end
   endtask

   task automatic hold(input bit vs, input logic lvl, input int n);
      repeat (n)
      begin
         @(posedge mclk);
         #1;
         chk(vs ? vsync_output : hsync_output, lvl);
      end
   endtask

   // Each output word is judged against the input word of the cycle before
   task automatic gchk(input bit gate, input logic [9:0] mid);
      vid_in_t s;
      @(posedge mclk);
      #1;
      s = vin;
      repeat (64)
      begin
         @(posedge mclk);
         #1;
         chk(vout.y, (gate && !s.field) ? BLANK_LOW : s.y);
         chk(vout.cb, (gate && !s.field) ? mid : s.cb);
         s = vin;
      end
   endtask

   initial
   begin
      repeat (8) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      chk(hsync_output, 1'b0);
      chk(vsync_output, 1'b1);
      wr(PPL_HI, 8'hAA);
      foreach (ra[i])
         rchk(ra[i], rv[i]);
      rchk(8'hF0, 8'h00);
      wr(HSW_LO, 8'h0A);
      wr(V2_HI, 8'h07);
      wr(VW2_LO, 8'h00);
      wr(VS2_LO, 8'hFF);
      wr(8'h50, 8'h30);
      wr(8'h51, 8'h01);
      wr(8'h52, 8'hA0);
      wr(8'h53, 8'h04);
      rchk(8'h52, 8'hA0);
      // Four frames: start-up delays pass and both measurements settle
      repeat (3072) @(posedge mclk);
      n3 = 0;
      na = 0;
      repeat (768)
      begin
         @(posedge mclk);
         #1;
         n3 += (line_kind === 4'h3);
         na += (line_kind === 4'hA);
      end
      chk(16'(n3), 16'h00C0);
      chk(16'(na), 16'h0240);
      rchk(PPL_HI, 8'h00);
      rchk(PPL_LO, 8'h40);
      rchk(SCAN_HI, 8'h00);
      rchk(LPF_LO, 8'h0C);
      wr(8'h50, 8'h00);
      wr(8'h52, 8'h00);
      wr(CTRL, 8'hDF);
      gchk(1'b1, BLANK_LOW);
      wr(CTRL, 8'h9F);
      gchk(1'b1, BLANK_MID);
      wr(FMT_SEL, 8'h04);
      gchk(1'b0, BLANK_MID);
      wr(FMT_SEL, 8'h06);
      wr(CTRL, 8'h5F);
      gchk(1'b0, BLANK_MID);
      ilace <= 1'b1;
      repeat (4608) @(posedge mclk);
      rchk(SCAN_HI, 8'h80);
      rchk(LPF_LO, 8'h18);
      // Moved only between pulses so no pulse is cut short
      wait_for(1'b1, 1'b0);
      wait_for(1'b1, 1'b1);
      wr(VS1_LO, 8'hC8);
      hold(1'b1, 1'b1, 1600);
      wait_for(1'b0, 1'b1);
      wait_for(1'b0, 1'b0);
      wr(HST_LO, 8'h64);
      hold(1'b0, 1'b0, 200);
      complete_run();
   end
endmodule // tb_top

bind video_timing_output vto_checker u_chk (.mclk(mclk), .arst_n(arst_n), .bus(bus),
   .rdata(rdata), .vin(vin), .vout(vout), .hsync_output(hsync_output),
   .vsync_output(vsync_output), .line_kind(line_kind));

// ===== tb/vid_src.sv
`timescale 1ns/1ps
module vid_src
#(
   parameter int HT = 64,
   parameter int VT = 12
)
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic ilace,
   output vtg_pkg::vid_in_t vin
);
   import vtg_pkg::*;
   int px;
   int ln;
   int pos;
   logic odd;

   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         px <= 0;
         ln <= 0;
         odd <= 1'b0;
      end
      else if (px == HT - 1)
      begin
         px <= 0;
         ln <= (ln == VT - 1) ? 0 : ln + 1;
         odd <= (ln == VT - 1) ? ilace && !odd : odd;
      end
      else
         px <= px + 1;
   end

   // Second field puts the vertical edge mid-line, as an interlaced source does
   assign pos = ln * HT + px - (odd ? HT / 2 : 0);
   always_comb
   begin
      vin.hsync = px < 4;
      vin.vsync = pos >= 0 && pos < 2 * HT;
      vin.field = px >= 16 && px < HT - 8;
      vin.y = 10'(px);
      vin.cb = 10'(~px);
      vin.cr = 10'(ln * 8);
   end
endmodule // vid_src

// ===== tb/vto_checker.sv
`timescale 1ns/1ps
module vto_checker
(
   input wire logic mclk,
   input wire logic arst_n,
   input vtg_pkg::reg_req_t bus,
   input wire logic [7:0] rdata,
   input vtg_pkg::vid_in_t vin,
   input vtg_pkg::vid_px_t vout,
   input wire logic hsync_output,
   input wire logic vsync_output,
   input wire logic [3:0] line_kind
);
   import vtg_pkg::*;
   logic [7:0] sh [8'h70:8'h82];
   logic [15:0] pc, per, hgap, hrun, vrun;
   logic seen;
   wire logic hs_act = hsync_output == sh[CTRL][CTL_HS_POL];
   wire logic vs_act = vsync_output != sh[CTRL][CTL_VS_POL];
   wire logic [15:0] hsw = {6'h00, sh[HSW_HST_HI][7:6], sh[HSW_LO]};
   wire logic [15:0] hst = {3'h0, sh[HSW_HST_HI][4:0], sh[HST_LO]};
   wire logic [15:0] vw1 = {6'h00, sh[V1_HI][7:6], sh[VW1_LO]};
   wire logic [9:0] chroma = sh[CTRL][CTL_COLOUR] ? BLANK_LOW : BLANK_MID;
   wire logic gate = sh[CTRL][CTL_FIELD_ROLE] &&
      (sh[FMT_SEL][3:0] == MODE_VESA_MASTER || sh[FMT_SEL][3:0] == MODE_VESA_SLAVE);

   // Shadow of the writable registers so the checks follow what software set
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < REG_COUNT; i++)
            sh[8'h70 + i] <= REG_RESET[i];
         pc <= '0;
         per <= '0;
         hgap <= '0;
         hrun <= '0;
         vrun <= '0;
         seen <= 1'b0;
      end
      else
      begin
         if (bus.wr && bus.addr >= REG_FIRST && bus.addr <= REG_LAST)
            sh[bus.addr] <= bus.wdata & REG_WMASK[bus.addr - REG_FIRST];
         pc <= $rose(vin.hsync) ? 16'h0001 : pc + 16'h0001;
         per <= $rose(vin.hsync) ? pc : per;
         hgap <= $rose(hs_act) ? 16'h0001 : hgap + 16'h0001;
         // A gap in the pulses must not count as a period
         seen <= $rose(hs_act) || (seen && hst < per);
         hrun <= hs_act ? hrun + 16'h0001 : '0;
         vrun <= vs_act ? vrun + 16'h0001 : '0;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);

   chk_de_blank_y: assert property (gate && !vin.field |=> vout.y == BLANK_LOW)
      else $error("luma not blanked outside data enable");
   chk_de_pass: assert property (gate && vin.field |=> vout == $past(vin[29:0]))
      else $error("data not passed while data enable high");
   chk_blank_place: assert property (gate && !vin.field |=>
      vout.cb == $past(chroma) && vout.cr == $past(chroma))
      else $error("chroma blanking level wrong");
   chk_hs_width: assert property ($fell(hs_act) |-> hrun == hsw)
      else $error("horizontal pulse width wrong");
   chk_hs_period: assert property ($rose(hs_act) && seen |-> hgap == per)
      else $error("horizontal pulse spacing wrong");
   chk_hs_silent: assert property ((hst > per && per != 16'h0000)[*3] |-> !hs_act)
      else $error("horizontal pulse with start beyond line");
   chk_vs_width: assert property ($fell(vs_act) && vrun > 16'h0008 |-> vrun == vw1 * per)
      else $error("vertical pulse length wrong");
   chk_vs_align: assert property ($rose(vs_act) && seen |-> hgap == per - hst)
      else $error("vertical pulse not on line start");
endmodule // vto_checker
